// File: src/sahc_map.svh
// How it works
// R1 - leaving closed loop needs the error magnitude within the entry threshold (up to 140).
// R2 - in hold, an error magnitude above the exit threshold (0 to 140) restores closed loop.
// R3 - with a non-negative entry threshold, entry also needs torque below the holding torque.
// R4 - a negative entry threshold skips the torque check on entry.
// R5 - both holding and moving torque limits at zero make the thresholds a plain dead-band.
// R6 - after entry conditions hold, entry waits 0 to 65535 ticks of 120 us, reset 1250.
// R7 - in mode 0 motion forces closed loop until it ends, error is low and the delay elapses.
// R8 - in mode 1 motion is ignored and hold persists while the error stays low enough.
// R9 - software should give a nonzero settle delay in mode 1 to stop chatter at low speed.
// R10 - the settle count restarts from zero whenever an entry condition lapses early.
// R11 - a negative entry threshold is compared by its absolute value.
`ifndef SAHC_MAP_SVH
`define SAHC_MAP_SVH
`define SAHC_CLK_HZ        40000000
`define SAHC_TICK_NS       120000
`define SAHC_TICK_CYC      ((`SAHC_CLK_HZ / 1000000) * `SAHC_TICK_NS / 1000)
`define SAHC_ADDR_THRESH   4'h0
`define SAHC_ADDR_DELAY    4'h1
`define SAHC_ADDR_MODE     4'h2
`define SAHC_ADDR_TORQUE   4'h3
`define SAHC_ADDR_STATUS   4'h4
`define SAHC_DELAY_RST     16'h04E2
`define SAHC_ENTRY_RST     16'h0004
`define SAHC_EXIT_RST      16'h000A
`endif

// File: src/sahc_pkg.sv
`default_nettype none
package sahc_pkg;
	typedef enum logic [0:0] {
		SAHC_CLOSED,
		SAHC_HOLD
	} sahc_state_t;
	typedef struct packed {
		logic [15:0] exit_thr;
		logic [15:0] entry_thr;
		logic [15:0] delay;
		logic        mode;
		logic [15:0] hold_tq;
		logic [15:0] move_tq;
	} sahc_cfg_t;
endpackage
`default_nettype wire

// File: src/sahc_tick_div.sv
`include "sahc_map.svh"
`default_nettype none
module sahc_tick_div #(
	parameter int CYC = `SAHC_TICK_CYC
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic clear,
	output var  logic tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} sahc_div_st_t;
	sahc_div_st_t st;
	sahc_div_st_t next_st;
	localparam logic [15:0] LAST = 16'(CYC - 1);
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (clear) begin
			next_st.cnt = 16'h0000;
		end else if (st.cnt == LAST) begin
			next_st.cnt = 16'h0000;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 16'h0001;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign tick = st.tick;
endmodule
`default_nettype wire

// File: src/sahc_top.sv
`include "sahc_map.svh"
`default_nettype none
module sahc_top #(
	parameter int EW = 16
) (
	input  wire logic          clk,
	input  wire logic          rst_b,
	input  wire logic [3:0]    reg_addr,
	input  wire logic [31:0]   reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output var  logic [31:0]   reg_rdata,
	input  wire logic [EW-1:0] pos_error,
	input  wire logic [15:0]   cmd_torque,
	input  wire logic          in_motion,
	output var  logic          open_loop_hold,
	output var  logic          entry_ok
);
	typedef struct packed {
		sahc_pkg::sahc_cfg_t   cfg;
		sahc_pkg::sahc_state_t state;
		logic                  hold;
		logic [15:0]           settle;
		logic                  ok;
		logic [31:0]           rdata;
	} sahc_st_t;
	sahc_st_t st;
	sahc_st_t next_st;
	logic     tick;
	logic     err_neg;
	logic [EW-1:0] err_mag;
	logic [15:0]   entry_mag;
	logic          err_in;
	logic          err_out;
	logic          tq_ok;
	logic          motion_ok;
	logic          cond;
	logic          deadband;
	// ------------------------------------------------------------
	// error and thresholds
	// ------------------------------------------------------------
	always_comb begin
		err_neg = pos_error[EW-1];
		err_mag = err_neg ? (~pos_error + {{(EW-1){1'b0}}, 1'b1}) : pos_error;
		entry_mag = st.cfg.entry_thr[15] ? (~st.cfg.entry_thr + 16'h0001)
			: st.cfg.entry_thr; // R11
		err_in = ({16'h0000, err_mag} <= {{EW{1'b0}}, entry_mag}); // R1
		err_out = ({16'h0000, err_mag} > {{EW{1'b0}}, st.cfg.exit_thr}); // R2
		// zero torque limits leave a pure position window, no torque gate
		deadband = (st.cfg.hold_tq == 16'h0000) && (st.cfg.move_tq == 16'h0000); // R5
		tq_ok = st.cfg.entry_thr[15] || deadband || (cmd_torque < st.cfg.hold_tq); // R3 R4
		motion_ok = st.cfg.mode || !in_motion; // R7 R8
		cond = err_in && tq_ok && motion_ok;
	end
	sahc_tick_div #(
		.CYC(`SAHC_TICK_CYC)
	) u_div (
		.clk  (clk),
		.rst_b(rst_b),
		.clear(!cond || (st.state == sahc_pkg::SAHC_HOLD)),
		.tick (tick)
	);
	// ------------------------------------------------------------
	// state and register port
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.ok = cond;
		next_st.rdata = 32'h0000_0000;
		unique case (st.state)
			sahc_pkg::SAHC_CLOSED: begin
				if (!cond) begin
					next_st.settle = 16'h0000; // R10
				end else if (st.settle >= st.cfg.delay) begin
					next_st.state = sahc_pkg::SAHC_HOLD; // R6
					next_st.settle = 16'h0000;
				end else if (tick) begin
					next_st.settle = st.settle + 16'h0001; // R6
				end
			end
			sahc_pkg::SAHC_HOLD: begin
				// mode 1 needs a nonzero delay from software or it chatters
				if (err_out || (!st.cfg.mode && in_motion)) begin
					next_st.state = sahc_pkg::SAHC_CLOSED; // R2 R7
				end
			end
		endcase
		if (reg_wr) begin
			unique case (reg_addr)
				`SAHC_ADDR_THRESH: begin
					next_st.cfg.exit_thr = reg_wdata[15:0];
					next_st.cfg.entry_thr = reg_wdata[31:16];
				end
				`SAHC_ADDR_DELAY: next_st.cfg.delay = reg_wdata[15:0];
				`SAHC_ADDR_MODE: next_st.cfg.mode = reg_wdata[0];
				`SAHC_ADDR_TORQUE: begin
					next_st.cfg.hold_tq = reg_wdata[15:0];
					next_st.cfg.move_tq = reg_wdata[31:16];
				end
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				`SAHC_ADDR_THRESH: next_st.rdata = {st.cfg.entry_thr, st.cfg.exit_thr};
				`SAHC_ADDR_DELAY: next_st.rdata = {16'h0000, st.cfg.delay};
				`SAHC_ADDR_MODE: next_st.rdata = {31'h0, st.cfg.mode};
				`SAHC_ADDR_TORQUE: next_st.rdata = {st.cfg.move_tq, st.cfg.hold_tq};
				`SAHC_ADDR_STATUS: next_st.rdata = {st.settle, 14'h0, st.ok, st.hold};
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end
		// hold pin comes straight from its own flop, no decode after the register
		next_st.hold = (next_st.state == sahc_pkg::SAHC_HOLD);
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.cfg.delay <= `SAHC_DELAY_RST;
			st.cfg.entry_thr <= `SAHC_ENTRY_RST;
			st.cfg.exit_thr <= `SAHC_EXIT_RST;
			st.state <= sahc_pkg::SAHC_CLOSED;
		end else begin
			st <= next_st;
		end
	end
	assign reg_rdata = st.rdata;
	assign open_loop_hold = st.hold;
	assign entry_ok = st.ok;
endmodule
`default_nettype wire

// File: testbench/sahc_props.sv
`default_nettype none
module sahc_props #(parameter int EW = 16) (
	input wire logic          clk,
	input wire logic          rst_b,
	input wire logic [3:0]    reg_addr,
	input wire logic          reg_rd,
	input wire logic [31:0]   reg_rdata,
	input wire logic [EW-1:0] pos_error,
	input wire logic [15:0]   cmd_torque,
	input wire logic          in_motion,
	input wire logic          open_loop_hold,
	input wire logic          entry_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	logic armed;
	// the release edge still finds the block in reset, so its attempts are skipped
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			armed <= 1'b0;
		end else begin
			armed <= 1'b1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b || !armed);
	sequence s_rd(a); reg_rd && reg_addr == a; endsequence
	sequence s_far; pos_error == 16'h7FFF; endsequence
	property p_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("rdata idle");
	property p_st0; s_rd(4'h4) |=> reg_rdata[0] == $past(open_loop_hold); endproperty
	a_st0: assert property (p_st0) else $error("status hold");
	property p_st1; s_rd(4'h4) |=> reg_rdata[1] == $past(entry_ok); endproperty
	a_st1: assert property (p_st1) else $error("status entry");
	property p_unmap; reg_rd && reg_addr > 4'h4 |=> reg_rdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_rise; $rose(open_loop_hold) |-> entry_ok; endproperty
	a_rise: assert property (p_rise) else $error("hold without entry");
	property p_near; !in_motion && pos_error == 0 && cmd_torque == 0 |=> entry_ok; endproperty
	a_near: assert property (p_near) else $error("entry missed");
	property p_far; s_far |=> !entry_ok; endproperty
	a_far: assert property (p_far) else $error("entry on big error");
	property p_exit; s_far |=> !open_loop_hold; endproperty
	a_exit: assert property (p_exit) else $error("hold on big error");
endmodule
bind sahc_top sahc_props #(.EW(EW)) u_props (
	.clk           (clk),
	.rst_b         (rst_b),
	.reg_addr      (reg_addr),
	.reg_rd        (reg_rd),
	.reg_rdata     (reg_rdata),
	.pos_error     (pos_error),
	.cmd_torque    (cmd_torque),
	.in_motion     (in_motion),
	.open_loop_hold(open_loop_hold),
	.entry_ok      (entry_ok)
);
`default_nettype wire

// File: testbench/sahc_servo_model.sv
`default_nettype none
module sahc_servo_model (
	input  wire logic        clk,
	input  wire logic [15:0] tgt_err,
	input  wire logic [15:0] tgt_tq,
	input  wire logic        tgt_mv,
	output var  logic [15:0] pos_error = 16'h0,
	output var  logic [15:0] cmd_torque = 16'h0,
	output var  logic        in_motion = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// one cycle of loop lag, so the block never sees a same-edge change
	always_ff @(posedge clk) begin
		pos_error <= tgt_err;
		cmd_torque <= tgt_tq;
		in_motion <= tgt_mv;
	end
endmodule
`default_nettype wire

// File: testbench/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, tgt_mv = 0;
	logic open_loop_hold, entry_ok, in_motion;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [15:0] tgt_err = 16'h0, tgt_tq = 16'h0, pos_error, cmd_torque;
	int n_mismatch = 0, comparisons = 0, n;
	sahc_top dut (
		.clk           (clk),
		.rst_b         (rst_b),
		.reg_addr      (reg_addr),
		.reg_wdata     (reg_wdata),
		.reg_wr        (reg_wr),
		.reg_rd        (reg_rd),
		.reg_rdata     (reg_rdata),
		.pos_error     (pos_error),
		.cmd_torque    (cmd_torque),
		.in_motion     (in_motion),
		.open_loop_hold(open_loop_hold),
		.entry_ok      (entry_ok)
	);
	sahc_servo_model plant (
		.clk       (clk),
		.tgt_err   (tgt_err),
		.tgt_tq    (tgt_tq),
		.tgt_mv    (tgt_mv),
		.pos_error (pos_error),
		.cmd_torque(cmd_torque),
		.in_motion (in_motion)
	);
	always #12.5 clk = ~clk;
	task report_and_stop;
		if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 0;
		#1 chk(reg_rdata, e);
	endtask
	// entry flag lands two edges after the plant target changes
	task set(input logic [15:0] e, input logic [15:0] t, input logic m);
		@(posedge clk);
		tgt_err <= e;
		tgt_tq <= t;
		tgt_mv <= m;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task wait_hold(input logic v);
		n = 0;
		while (open_loop_hold !== v && n < 20000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 20000) begin
			chk(0, 1);
			report_and_stop();
		end
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1;
		rd(4'h0, 32'h0004000A);
		rd(4'h1, 32'h000004E2);
		rd(4'h3, 32'h0);
		rd(4'h5, 32'h0);
		set(16'd20, 0, 0);
		chk(entry_ok, 0);
		wr(4'h1, 32'h2);
		set(0, 0, 0);
		repeat (7200) @(posedge clk);
		set(16'd20, 0, 0);
		set(0, 0, 0);
		wait_hold(1);
		chk(n > 9000 && n < 10000, 1);
		set(16'd10, 0, 0);
		chk(open_loop_hold, 1);
		set(16'd11, 0, 0);
		chk(open_loop_hold, 0);
		set(16'h7FFF, 0, 0);
		set(0, 0, 0);
		wait_hold(1);
		set(0, 0, 1);
		chk(open_loop_hold, 0);
		rd(4'h4, 32'h0);
		wr(4'h2, 32'h1);
		wait_hold(1);
		set(0, 0, 1);
		chk(open_loop_hold, 1);
		wr(4'h3, 32'h00050005);
		set(16'd3, 16'd9, 0);
		chk(entry_ok, 0);
		set(16'd3, 16'd4, 0);
		chk(entry_ok, 1);
		wr(4'h0, 32'hFFFC000A);
		set(16'hFFFC, 16'd9, 0);
		chk(entry_ok, 1);
		wr(4'h3, 32'h0);
		wr(4'h0, 32'h0004000A);
		set(16'd3, 16'd9, 0);
		chk(entry_ok, 1);
		report_and_stop();
	end
endmodule
`default_nettype wire
